// >>> verilog/bst_defs.vh
`ifndef BST_DEFS_VH
`define BST_DEFS_VH
// ****************************************
// tap controller states
// ****************************************
`define BST_TLR 4'h0
`define BST_RTI 4'h1
`define BST_SDR 4'h2
`define BST_CDR 4'h3
`define BST_SHDR 4'h4
`define BST_E1DR 4'h5
`define BST_PDR 4'h6
`define BST_E2DR 4'h7
`define BST_UDR 4'h8
`define BST_SIR 4'h9
`define BST_CIR 4'ha
`define BST_SHIR 4'hb
`define BST_E1IR 4'hc
`define BST_PIR 4'hd
`define BST_E2IR 4'he
`define BST_UIR 4'hf
// ****************************************
// instruction codes and widths
// ****************************************
`define BST_IR_W 4
`define BST_OP_EXTEST 4'h0
`define BST_OP_SAMPLE 4'h1
`define BST_OP_IDCODE 4'h2
`define BST_OP_BYPASS 4'hf
`define BST_IR_CAPTURE 4'h1
// ****************************************
// identification fields
// ****************************************
`define BST_VER_W 4
`define BST_PART_W 16
`define BST_MFR_W 11
`endif

// >>> verilog/bst_tap.v
`timescale 1ns/100ps
`include "bst_defs.vh"
// What this block does
// - pulling the test reset low sends the controller to test-logic-reset at once, clock or not.
// - the port is just five pins: mode select, test clock, data in, data out and test reset.
// - every digital pin has a cell, chained into one register.
// - vectors of any length shift in on data in and captured data shifts out on data out.
// - the identification register holds a version, a 16-bit part number and an 11-bit maker.
// - the identification register sits between the data pins only under the id instruction.
// - four instructions are decoded: sample/preload, extest, id code and bypass.
// - instructions are reached through the sixteen-state controller stepped by mode select.
module bst_tap #(
   parameter NCELL = 8,
   parameter [3:0] VERSION = 4'h0,
   // arbitrary neutral identity values
   parameter [15:0] PART_NUM = 16'h1234,
   parameter [10:0] MFR_ID = 11'h055
) (
   // system
   input wire i_clk,
   input wire i_rst_n,
   // test port pins
   input wire i_tck,
   input wire i_tms,
   input wire i_tdi,
   input wire i_trst_n,
   output reg o_tdo,
   output reg o_tdo_oe,
   // boundary cells: core side and pin side
   input wire [NCELL-1:0] i_pin_in,
   input wire [NCELL-1:0] i_core_out,
   output reg [NCELL-1:0] o_pin_out,
   output reg o_extest
);
   // ****************************************
   // synchronisers
   // ****************************************
   reg [1:0] tck_s_ff, tms_s_ff, tdi_s_ff;
   reg tck_d_ff;
   reg [1:0] trst_s_ff;
   wire trst_n;
   wire rise;
   wire fall;
   reg [3:0] st_ff;
   reg [3:0] nxt_st;
   reg [`BST_IR_W-1:0] ir_sh_ff, ir_ff;
   reg [31:0] dr_sh_ff;
   reg [NCELL-1:0] upd_ff;
   reg [NCELL-1:0] pin_s0_ff;
   reg [NCELL-1:0] pin_s1_ff;
   wire [31:0] id_val;
   wire sel_ext;
   wire sel_smp;
   wire sel_id;
   wire sel_bnd;
   wire tlr_rise;

   // trst reaches the state asynchronously; a released copy is synchronised for the rest
   always @(posedge i_clk or negedge i_rst_n or negedge i_trst_n) begin
      if (!i_rst_n || !i_trst_n) begin
         trst_s_ff <= 2'h0;
      end else begin
         trst_s_ff <= {trst_s_ff[0], 1'b1};
      end
   end
   assign trst_n = trst_s_ff[1];

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tck_s_ff <= 2'h0;
         tms_s_ff <= 2'h3;
         tdi_s_ff <= 2'h3;
         tck_d_ff <= 1'b0;
      end else begin
         tck_s_ff <= {tck_s_ff[0], i_tck};
         tms_s_ff <= {tms_s_ff[0], i_tms};
         tdi_s_ff <= {tdi_s_ff[0], i_tdi};
         tck_d_ff <= tck_s_ff[1];
      end
   end
   // tck runs far slower than i_clk, so edge detection on the synced copy is safe
   assign rise = tck_s_ff[1] & ~tck_d_ff;
   assign fall = ~tck_s_ff[1] & tck_d_ff;

   // pin levels come from other chips on the board; each bit is a level of its own,
   // so a plain two-stage sync per bit is enough and no handshake is needed
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_s0_ff <= {NCELL{1'b0}};
         pin_s1_ff <= {NCELL{1'b0}};
      end else begin
         pin_s0_ff <= i_pin_in;
         pin_s1_ff <= pin_s0_ff;
      end
   end

   // ****************************************
   // tap controller
   // ****************************************
   // every state lists both exits, so only a corrupted code reaches the default
   always @* begin
      nxt_st = st_ff;
      case (st_ff)
         `BST_TLR: nxt_st = tms_s_ff[1] ? `BST_TLR : `BST_RTI;
         `BST_RTI: nxt_st = tms_s_ff[1] ? `BST_SDR : `BST_RTI;
         `BST_SDR: nxt_st = tms_s_ff[1] ? `BST_SIR : `BST_CDR;
         `BST_CDR: nxt_st = tms_s_ff[1] ? `BST_E1DR : `BST_SHDR;
         `BST_SHDR: nxt_st = tms_s_ff[1] ? `BST_E1DR : `BST_SHDR;
         `BST_E1DR: nxt_st = tms_s_ff[1] ? `BST_UDR : `BST_PDR;
         `BST_PDR: nxt_st = tms_s_ff[1] ? `BST_E2DR : `BST_PDR;
         `BST_E2DR: nxt_st = tms_s_ff[1] ? `BST_UDR : `BST_SHDR;
         `BST_UDR: nxt_st = tms_s_ff[1] ? `BST_SDR : `BST_RTI;
         `BST_SIR: nxt_st = tms_s_ff[1] ? `BST_TLR : `BST_CIR;
         `BST_CIR: nxt_st = tms_s_ff[1] ? `BST_E1IR : `BST_SHIR;
         `BST_SHIR: nxt_st = tms_s_ff[1] ? `BST_E1IR : `BST_SHIR;
         `BST_E1IR: nxt_st = tms_s_ff[1] ? `BST_UIR : `BST_PIR;
         `BST_PIR: nxt_st = tms_s_ff[1] ? `BST_E2IR : `BST_PIR;
         `BST_E2IR: nxt_st = tms_s_ff[1] ? `BST_UIR : `BST_SHIR;
         `BST_UIR: nxt_st = tms_s_ff[1] ? `BST_SDR : `BST_RTI;
         default: nxt_st = `BST_TLR;
      endcase
   end

   // the board ties trst low when unused, which parks the controller here
   always @(posedge i_clk or negedge i_rst_n or negedge i_trst_n) begin
      if (!i_rst_n || !i_trst_n) begin
         st_ff <= `BST_TLR;
      end else if (!trst_n) begin
         st_ff <= `BST_TLR;
      end else if (rise) begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************
   // instruction and data registers
   // ****************************************
   assign id_val = {VERSION, PART_NUM, MFR_ID, 1'b1};

   // unlisted codes fall through to bypass, so a stray opcode never opens the pins
   assign sel_ext = (ir_ff == `BST_OP_EXTEST);
   assign sel_smp = (ir_ff == `BST_OP_SAMPLE);
   assign sel_id = (ir_ff == `BST_OP_IDCODE);
   assign sel_bnd = sel_ext | sel_smp;
   assign tlr_rise = rise & (st_ff == `BST_TLR);

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ir_sh_ff <= `BST_OP_BYPASS;
         ir_ff <= `BST_OP_BYPASS;
      end else if (!trst_n || tlr_rise) begin
         ir_ff <= `BST_OP_BYPASS;
         ir_sh_ff <= `BST_OP_BYPASS;
      end else if (rise) begin
         case (st_ff)
            `BST_CIR: ir_sh_ff <= `BST_IR_CAPTURE;
            `BST_SHIR: ir_sh_ff <= {tdi_s_ff[1], ir_sh_ff[`BST_IR_W-1:1]};
            `BST_UIR: ir_ff <= ir_sh_ff;
            default: ir_sh_ff <= ir_sh_ff;
         endcase
      end
   end

   // the shift register is 32 wide for the id; boundary and bypass use its low bits only
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dr_sh_ff <= 32'h0;
         upd_ff <= {NCELL{1'b0}};
      end else if (rise) begin
         case (st_ff)
            `BST_CDR: begin
               dr_sh_ff <= 32'h0;
               if (sel_id) begin
                  dr_sh_ff <= id_val;
               end else if (sel_bnd) begin
                  dr_sh_ff[NCELL-1:0] <= sel_ext ? pin_s1_ff : i_core_out;
               end
            end
            `BST_SHDR: begin
               if (sel_id) begin
                  dr_sh_ff <= {tdi_s_ff[1], dr_sh_ff[31:1]};
               end else if (sel_bnd) begin
                  dr_sh_ff[NCELL-1:0] <= {tdi_s_ff[1], dr_sh_ff[NCELL-1:1]};
               end else begin
                  dr_sh_ff[0] <= tdi_s_ff[1];
               end
            end
            `BST_UDR: begin
               if (sel_bnd) begin
                  upd_ff <= dr_sh_ff[NCELL-1:0]; // preload
               end
            end
            default: upd_ff <= upd_ff;
         endcase
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // tdo changes on the falling tck edge so the tester samples it stable on the rise
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_tdo <= 1'b0;
         o_tdo_oe <= 1'b0;
         o_pin_out <= {NCELL{1'b0}};
         o_extest <= 1'b0;
      end else begin
         // pins follow the core one clock late outside extest, which keeps them flops
         o_extest <= sel_ext;
         o_pin_out <= sel_ext ? upd_ff : i_core_out;
         if (!trst_n) begin
            o_tdo_oe <= 1'b0;
         end else if (fall) begin
            o_tdo_oe <= (st_ff == `BST_SHDR) || (st_ff == `BST_SHIR);
            o_tdo <= (st_ff == `BST_SHIR) ? ir_sh_ff[0] : dr_sh_ff[0];
         end
      end
   end
endmodule

// >>> dv/bst_tap_checker.sv
`timescale 1ns/100ps
module bst_tap_checker #(parameter NCELL = 8) (
   // system
   input wire i_clk,
   input wire i_rst_n,
   // test port pins
   input wire i_tck,
   input wire i_tms,
   input wire i_tdi,
   input wire i_trst_n,
   input wire o_tdo,
   input wire o_tdo_oe,
   // boundary cells
   input wire [NCELL-1:0] i_pin_in,
   input wire [NCELL-1:0] i_core_out,
   input wire [NCELL-1:0] o_pin_out,
   input wire o_extest
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // tck has been high for four clocks: any fall-launched update has landed by now
   sequence s_high; $rose(i_tck) ##1 (i_tck && i_trst_n) [*3]; endsequence
   property p_tdo_hold; s_high |-> $stable(o_tdo); endproperty
   a_tdo_hold: assert property (p_tdo_hold) else $error("tdo moved in tck high");
   property p_oe_hold; s_high |-> $stable(o_tdo_oe); endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("oe moved in tck high");
   property p_tdo_fall; $changed(o_tdo) && i_trst_n && $past(i_trst_n) |-> !$past(i_tck, 2);
   endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("tdo not after tck fall");
   property p_oe_rise; $rose(o_tdo_oe) |-> !$past(i_tck, 2); endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("oe not after tck fall");
   property p_trst; (!i_trst_n) [*3] |-> !o_tdo_oe && !o_extest; endproperty
   a_trst: assert property (p_trst) else $error("test reset ignored");
   property p_ext_trst; $rose(o_extest) |-> $past(i_trst_n, 3); endproperty
   a_ext_trst: assert property (p_ext_trst) else $error("extest out of reset");
   property p_pass; !o_extest && $past(!o_extest) && $past(i_rst_n)
      |-> o_pin_out == $past(i_core_out); endproperty
   a_pass: assert property (p_pass) else $error("pins not from core");
   property p_rst; disable iff (1'b0) !i_rst_n |-> o_pin_out == 0 && !o_tdo && !o_tdo_oe;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not reset");
endmodule
bind bst_tap bst_tap_checker #(.NCELL(NCELL)) i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi), .i_trst_n(i_trst_n), .o_tdo(o_tdo),
   .o_tdo_oe(o_tdo_oe), .i_pin_in(i_pin_in), .i_core_out(i_core_out),
   .o_pin_out(o_pin_out), .o_extest(o_extest));

// >>> dv/bst_jtag_model.sv
`timescale 1ns/100ps
module bst_jtag_model (
   input wire i_clk,
   input wire i_tdo,
   input wire i_tdo_oe,
   output reg o_tck,
   output reg o_tms,
   output reg o_tdi
);
   initial begin
      o_tck = 1'h0;
      o_tms = 1'h1;
      o_tdi = 1'h0;
   end
   // four clocks per phase so each tck level outlasts the pin synchronisers
   task step(input bit m, input bit d, output logic q);
      begin
         o_tms = m;
         o_tdi = d;
         repeat (4) @(posedge i_clk);
         // a released line reads back inverted, so a missing enable shows as a bad bit
         #1 q = i_tdo_oe ? i_tdo : ~i_tdo;
         o_tck = 1'h1;
         repeat (4) @(posedge i_clk);
         #1 o_tck = 1'h0;
      end
   endtask
   // from run-test-idle through one scan, back to run-test-idle
   task scan(input bit ir, input bit [63:0] din, input int n, output logic [63:0] dout);
      logic q;
      begin
         dout = 64'h0;
         step(1'h1, 1'h0, q);
         if (ir) step(1'h1, 1'h0, q);
         step(1'h0, 1'h0, q);
         step(1'h0, 1'h0, q);
         for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
         end
         step(1'h1, 1'h0, q);
         step(1'h0, 1'h0, q);
      end
   endtask
endmodule

// >>> dv/bst_tap_tb.sv
`timescale 1ns/100ps
`include "bst_defs.vh"
module bst_tap_tb;
   localparam [3:0] VER = 4'h3; // identity values are arbitrary
   localparam [15:0] PART = 16'h5a3c;
   localparam [10:0] MFR = 11'h2e9;
   reg i_clk, i_rst_n, i_trst_n;
   reg [7:0] i_pin_in, i_core_out;
   wire tck, tms, tdi, o_tdo, o_tdo_oe, o_extest;
   wire [7:0] o_pin_out;
   int bad_count = 0;
   int comparisons = 0;
   logic [63:0] dout;
   bit [63:0] din;
   logic q;
   bst_tap #(.NCELL(8), .VERSION(VER), .PART_NUM(PART), .MFR_ID(MFR)) i_dut (.i_clk(i_clk),
      .i_rst_n(i_rst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst_n(i_trst_n),
      .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_pin_in(i_pin_in), .i_core_out(i_core_out),
      .o_pin_out(o_pin_out), .o_extest(o_extest));
   bst_jtag_model i_jtag (.i_clk(i_clk), .i_tdo(o_tdo), .i_tdo_oe(o_tdo_oe), .o_tck(tck),
      .o_tms(tms), .o_tdi(tdi));
   initial begin
      i_clk = 1'h0;
      forever #12.5 i_clk = ~i_clk;
   end
   task check(input string name, input logic [63:0] e, input logic [63:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, e, g);
      end
   endtask
   task complete_run;
      $display("checks %0d errors %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task ir(input bit [3:0] code);
      i_jtag.scan(1'h1, code, 4, dout);
      check("ir capture", `BST_IR_CAPTURE, dout[3:0]);
   endtask
   task bypass;
      bit bq[$];
      logic [63:0] ref_v;
      din = {$urandom, $urandom};
      // reference path: the one-bit stage holds its captured zero ahead of the vector
      bq = {1'b0};
      for (int i = 0; i < 33; i++) bq.push_back(din[i]);
      ref_v = 64'h0;
      for (int i = 0; i < 33; i++) ref_v[i] = bq.pop_front();
      i_jtag.scan(1'h0, din, 33, dout);
      check("bypass", ref_v[32:0], dout[32:0]);
   endtask
   initial begin
      repeat (90000) @(posedge i_clk);
      bad_count++;
      complete_run;
   end
   initial begin
      i_rst_n = 1'h0;
      i_trst_n = 1'h0;
      i_pin_in = 8'h0;
      i_core_out = 8'h0;
      void'($urandom(92178));
      repeat (4) @(posedge i_clk);
      #1 i_rst_n = 1'h1;
      i_trst_n = 1'h1;
      repeat (3) @(posedge i_clk);
      #1 i_jtag.step(1'h0, 1'h0, q);
      bypass();
      ir(`BST_OP_IDCODE);
      i_jtag.scan(1'h0, 64'h0, 32, dout);
      check("idcode", {VER, PART, MFR, 1'h1}, dout[31:0]);
      i_core_out = 8'($urandom);
      din = {32'h0, $urandom};
      ir(`BST_OP_SAMPLE);
      i_jtag.scan(1'h0, din, 8, dout);
      check("sample", i_core_out, dout[7:0]);
      ir(`BST_OP_EXTEST);
      check("extest pins", {1'h1, din[7:0]}, {o_extest, o_pin_out});
      i_pin_in = 8'($urandom);
      din = {32'h0, $urandom};
      i_jtag.scan(1'h0, din, 8, dout);
      check("capture", i_pin_in, dout[7:0]);
      check("update", din[7:0], o_pin_out);
      i_trst_n = 1'h0;
      repeat (3) @(posedge i_clk);
      #1 check("test reset", 1'h0, o_extest);
      check("tdo released", 1'h0, o_tdo_oe);
      i_trst_n = 1'h1;
      repeat (3) @(posedge i_clk);
      #1 i_jtag.step(1'h0, 1'h0, q);
      bypass();
      ir(4'(3 + $urandom % 12));
      bypass();
      complete_run;
   end
endmodule
